// ===== shared/frame_pkg.sv
// constants and types for the serial frame control decoder
// assumes a host that frames address, control and data phases msb first
package frame_pkg;

    // frame layout: widths of each phase in bits
    localparam int ADDR_BITS = 16;
    localparam int CTRL_BITS = 8;
    localparam int DATA_BITS = 8;

    // field positions inside the control byte
    localparam int BLOCK_MSB = 7;
    localparam int BLOCK_LSB = 3;
    localparam int DIR_POS = 2;
    localparam int MODE_MSB = 1;
    localparam int MODE_LSB = 0;

    // direction bit encodings
    localparam logic DIR_READ = 1'h0;
    localparam logic DIR_WRITE = 1'h1;

    // length mode encodings
    localparam logic [1:0] MODE_VARIABLE = 2'h0;
    localparam logic [1:0] MODE_FIXED_1 = 2'h1;
    localparam logic [1:0] MODE_FIXED_2 = 2'h2;
    localparam logic [1:0] MODE_FIXED_4 = 2'h3;

    // data byte counts of the fixed length modes
    localparam logic [2:0] LEN_FIXED_1 = 3'h1;
    localparam logic [2:0] LEN_FIXED_2 = 3'h2;
    localparam logic [2:0] LEN_FIXED_4 = 3'h4;

    // block select decode
    localparam logic [4:0] BLOCK_COMMON = 5'h00;
    localparam logic [1:0] SUB_SOCK_REG = 2'h1;
    localparam logic [1:0] SUB_TX_BUF = 2'h2;
    localparam logic [1:0] SUB_RX_BUF = 2'h3;

    // reset values
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [4:0] CNT_RESET = 5'h00;

    // last bit index of each phase
    localparam logic [4:0] ADDR_LAST = 5'h0f;
    localparam logic [4:0] CTRL_LAST = 5'h07;
    localparam logic [4:0] DATA_LAST = 5'h07;

    // width of the request payload crossing to the system clock
    localparam int REQ_BITS = ADDR_BITS + CTRL_BITS + DATA_BITS;

    // target of a decoded access
    typedef enum logic [2:0] {
        KIND_COMMON   = 3'b000,
        KIND_SOCK_REG = 3'b001,
        KIND_TX_BUF   = 3'b010,
        KIND_RX_BUF   = 3'b011,
        KIND_RESERVED = 3'b100
    } kind_type;

    // phase of the frame on the serial link
    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_CTRL = 2'b01,
        PH_DATA = 2'b10
    } phase_type;

endpackage

// ===== hdl/event_sync.sv
// carries an event with a payload word from one clock to another
// assumes a new event comes only after the previous one has landed
module event_sync #(
    parameter int WIDTH = 8
) (
    // source side
    input wire logic src_clk,
    input wire logic src_rst,
    input wire logic src_fire,
    input wire logic [WIDTH-1:0] src_data,
    // destination side
    input wire logic dst_clk,
    input wire logic dst_rst,
    output logic dst_pulse,
    output logic [WIDTH-1:0] dst_data
);

    logic tog_q;
    logic [WIDTH-1:0] hold_q;
    logic sync1_q;
    logic sync2_q;
    logic sync3_q;

    // source flips a toggle and holds the payload steady
    always_ff @(posedge src_clk or posedge src_rst) begin
        if (src_rst) begin
            tog_q <= 1'h0;
            hold_q <= '0;
        end else if (src_fire) begin
            tog_q <= ~tog_q;
            hold_q <= src_data;
        end
    end

    // two flops on the toggle, a third finds its edge
    always_ff @(posedge dst_clk or posedge dst_rst) begin
        if (dst_rst) begin
            sync1_q <= 1'h0;
            sync2_q <= 1'h0;
            sync3_q <= 1'h0;
        end else begin
            sync1_q <= tog_q;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // payload is stable by the time the toggle arrives
    always_ff @(posedge dst_clk or posedge dst_rst) begin
        if (dst_rst) begin
            dst_pulse <= 1'h0;
            dst_data <= '0;
        end else begin
            dst_pulse <= sync2_q ^ sync3_q;
            if (sync2_q ^ sync3_q) begin
                dst_data <= hold_q;
            end
        end
    end

endmodule

// ===== hdl/frame_decode.sv
// serial slave frame decoder: address, control byte and data phase
// assumes spi_clk and chip_select_n come from the host; the system side
// answers read requests through rd_valid and rd_data
module frame_decode (
    // system clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // serial link from the host
    input wire logic spi_clk,
    input wire logic chip_select_n,
    input wire logic mosi,
    output logic miso_out,
    output logic miso_oe_n,
    // decoded access towards the system side
    output logic acc_valid,
    output logic acc_write,
    output frame_pkg::kind_type acc_kind,
    output logic [2:0] acc_socket,
    output logic [15:0] acc_addr,
    output logic [7:0] acc_wdata,
    output logic acc_reserved,
    // read answer from the system side
    input wire logic rd_valid,
    input wire logic [7:0] rd_data
);

    // link side state
    frame_pkg::phase_type phase_q;
    logic [4:0] cnt_q;
    logic [15:0] addr_q;
    logic [7:0] ctrl_q;
    logic [7:0] shift_q;
    logic [2:0] bytes_q;
    logic [7:0] tx_q;
    logic oe_n_q;

    // derived link values
    logic link_arst;
    logic [7:0] ctrl_next;
    logic [7:0] byte_next;
    logic [2:0] bytes_next;
    logic ctrl_done;
    logic byte_done;
    logic fixed_last;
    logic is_read;
    logic wr_fire;
    logic rd_fire;
    logic req_fire;
    logic [15:0] req_addr;
    logic [frame_pkg::REQ_BITS-1:0] req_payload;

    // system side of the crossings
    logic req_pulse;
    logic [frame_pkg::REQ_BITS-1:0] req_word;
    logic [7:0] rd_link_data;
    logic [15:0] word_addr;
    logic [7:0] word_ctrl;
    logic [7:0] word_data;
    frame_pkg::kind_type word_kind;

    // data byte count of a length mode, zero for variable length
    function automatic logic [2:0] fixed_len(input logic [1:0] mode);
        logic [2:0] len;
        len = 3'h0;
        unique case (mode)
            frame_pkg::MODE_VARIABLE: len = 3'h0;
            frame_pkg::MODE_FIXED_1: len = frame_pkg::LEN_FIXED_1;
            frame_pkg::MODE_FIXED_2: len = frame_pkg::LEN_FIXED_2;
            frame_pkg::MODE_FIXED_4: len = frame_pkg::LEN_FIXED_4;
        endcase
        return len;
    endfunction

    // target block of a block select code
    function automatic frame_pkg::kind_type block_kind(input logic [4:0] blk);
        frame_pkg::kind_type kind;
        kind = frame_pkg::KIND_RESERVED;
        if (blk == frame_pkg::BLOCK_COMMON) begin
            kind = frame_pkg::KIND_COMMON;
        end else begin
            unique case (blk[1:0])
                frame_pkg::SUB_SOCK_REG: kind = frame_pkg::KIND_SOCK_REG;
                frame_pkg::SUB_TX_BUF: kind = frame_pkg::KIND_TX_BUF;
                frame_pkg::SUB_RX_BUF: kind = frame_pkg::KIND_RX_BUF;
                2'h0: kind = frame_pkg::KIND_RESERVED;
            endcase
        end
        return kind;
    endfunction

    // select and reset both clear the link asynchronously, so a frame cut
    // anywhere leaves no half-counted bits behind
    // select high holds the link logic idle; its fall starts a frame
    assign link_arst = chip_select_n | sys_rst;

    // values formed on the sampling edge
    assign ctrl_next = {ctrl_q[6:0], mosi};
    assign byte_next = {shift_q[6:0], mosi};
    assign bytes_next = bytes_q + 3'h1;
    assign ctrl_done = (phase_q == frame_pkg::PH_CTRL) &&
        (cnt_q == frame_pkg::CTRL_LAST);
    assign byte_done = (phase_q == frame_pkg::PH_DATA) &&
        (cnt_q == frame_pkg::DATA_LAST);
    // the byte count wraps after eight bytes, so variable frames must be
    // kept out of the compare or a long frame would end by itself
    assign fixed_last = byte_done &&
        ctrl_q[frame_pkg::MODE_MSB:frame_pkg::MODE_LSB] !=
        frame_pkg::MODE_VARIABLE && (fixed_len(
        ctrl_q[frame_pkg::MODE_MSB:frame_pkg::MODE_LSB]) == bytes_next);
    assign is_read = ctrl_q[frame_pkg::DIR_POS] == frame_pkg::DIR_READ;

    // a write hands over each byte; a read fetches the next byte ahead
    // the fetch after the last byte of a variable frame is wasted: the
    // system side sees one extra read strobe
    assign wr_fire = byte_done && !is_read;
    assign rd_fire = (ctrl_done &&
        ctrl_next[frame_pkg::DIR_POS] == frame_pkg::DIR_READ) ||
        (byte_done && is_read && !fixed_last);
    assign req_fire = wr_fire || rd_fire;
    assign req_addr = (byte_done && is_read) ? addr_q + 16'h0001 : addr_q;
    assign req_payload = {req_addr, ctrl_done ? ctrl_next : ctrl_q,
        byte_next};

    // phase sequencing, sampled on the rising clock edge
    // in fixed frames the phase wraps to the address with no select edge
    always_ff @(posedge spi_clk or posedge link_arst) begin
        if (link_arst) begin
            phase_q <= frame_pkg::PH_ADDR;
            cnt_q <= frame_pkg::CNT_RESET;
            bytes_q <= 3'h0;
        end else begin
            unique case (phase_q)
                frame_pkg::PH_ADDR: begin
                    if (cnt_q == frame_pkg::ADDR_LAST) begin
                        phase_q <= frame_pkg::PH_CTRL;
                        cnt_q <= frame_pkg::CNT_RESET;
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                frame_pkg::PH_CTRL: begin
                    if (ctrl_done) begin
                        phase_q <= frame_pkg::PH_DATA;
                        cnt_q <= frame_pkg::CNT_RESET;
                        bytes_q <= 3'h0;
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                frame_pkg::PH_DATA: begin
                    if (fixed_last) begin
                        phase_q <= frame_pkg::PH_ADDR;
                        cnt_q <= frame_pkg::CNT_RESET;
                    end else if (byte_done) begin
                        cnt_q <= frame_pkg::CNT_RESET;
                        bytes_q <= bytes_next;
                    end else begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                default: begin
                    phase_q <= frame_pkg::PH_ADDR;
                    cnt_q <= frame_pkg::CNT_RESET;
                end
            endcase
        end
    end

    // offset address: shifted in, then stepped after each data byte
    always_ff @(posedge spi_clk or posedge link_arst) begin
        if (link_arst) begin
            addr_q <= frame_pkg::ADDR_RESET;
        end else if (phase_q == frame_pkg::PH_ADDR) begin
            addr_q <= {addr_q[14:0], mosi};
        end else if (byte_done) begin
            addr_q <= addr_q + 16'h0001;
        end
    end

    // control byte and data shift register
    always_ff @(posedge spi_clk or posedge link_arst) begin
        if (link_arst) begin
            ctrl_q <= frame_pkg::CTRL_RESET;
            shift_q <= frame_pkg::DATA_RESET;
        end else begin
            if (phase_q == frame_pkg::PH_CTRL) begin
                ctrl_q <= ctrl_next;
            end
            shift_q <= byte_next;
        end
    end

    // read data leaves on the falling edge, msb first
    // the byte is taken at the first falling edge of each data byte, so it
    // must have been answered before the host resumes the clock
    always_ff @(negedge spi_clk or posedge link_arst) begin
        if (link_arst) begin
            tx_q <= frame_pkg::DATA_RESET;
            oe_n_q <= 1'h1;
        end else if (phase_q == frame_pkg::PH_DATA && is_read) begin
            oe_n_q <= 1'h0;
            if (cnt_q == frame_pkg::CNT_RESET) begin
                tx_q <= rd_link_data;
            end else begin
                tx_q <= {tx_q[6:0], 1'h0};
            end
        end else begin
            oe_n_q <= 1'h1;
        end
    end

    assign miso_out = tx_q[7];
    assign miso_oe_n = oe_n_q;

    // requests from the link to the system clock
    // requests come at least one byte apart, far slower than the crossing
    event_sync #(
        .WIDTH(frame_pkg::REQ_BITS)
    ) req_sync (
        .src_clk(spi_clk),
        .src_rst(sys_rst),
        .src_fire(req_fire),
        .src_data(req_payload),
        .dst_clk(ref_clk),
        .dst_rst(sys_rst),
        .dst_pulse(req_pulse),
        .dst_data(req_word)
    );

    // read answers held on the system clock for the link to pick up;
    // the link clock stands still while the host waits for the answer, so
    // a synchroniser on it could never pass the word in time; the word is
    // instead held steady and read only after that pause
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rd_link_data <= frame_pkg::DATA_RESET;
        end else if (rd_valid) begin
            rd_link_data <= rd_data;
        end
    end

    // unpack the landed request
    // fields stay put between requests, so the user may read them late
    assign word_addr = req_word[frame_pkg::REQ_BITS-1 -: 16];
    assign word_ctrl = req_word[15:8];
    assign word_data = req_word[7:0];
    assign word_kind = block_kind(
        word_ctrl[frame_pkg::BLOCK_MSB:frame_pkg::BLOCK_LSB]);

    // one-cycle access strobes on the system clock
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            acc_valid <= 1'h0;
            acc_reserved <= 1'h0;
        end else begin
            acc_valid <= req_pulse &&
                word_kind != frame_pkg::KIND_RESERVED;
            acc_reserved <= req_pulse &&
                word_kind == frame_pkg::KIND_RESERVED;
        end
    end

    // access fields, held until the next request lands
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            acc_write <= 1'h0;
            acc_kind <= frame_pkg::KIND_COMMON;
            acc_socket <= 3'h0;
            acc_addr <= frame_pkg::ADDR_RESET;
            acc_wdata <= frame_pkg::DATA_RESET;
        end else if (req_pulse) begin
            acc_write <= word_ctrl[frame_pkg::DIR_POS] ==
                frame_pkg::DIR_WRITE;
            acc_kind <= word_kind;
            acc_socket <= word_ctrl[frame_pkg::BLOCK_MSB:5];
            acc_addr <= word_addr;
            acc_wdata <= word_data;
        end
    end

endmodule

// ===== tb/frame_decode_sva.sv
// checker for the frame decoder's decoded accesses and read driver
// assumes registered outputs sampled on ref_clk, bound to frame_decode
module frame_decode_sva (
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // link side
    input wire logic chip_select_n,
    input wire logic miso_oe_n,
    // decoded access
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire frame_pkg::kind_type acc_kind,
    input wire logic [2:0] acc_socket,
    input wire logic [15:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    input wire logic acc_reserved,
    // read answer from the system side
    input wire logic rd_valid
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    // refusals and targets of decoded accesses
    valid_excl_a: assert property (acc_valid |-> !acc_reserved)
        else $error("access and refusal in one cycle");
    reserved_kind_a: assert property (
        acc_reserved |-> acc_kind == frame_pkg::KIND_RESERVED)
        else $error("refusal without reserved kind");
    valid_kind_a: assert property (
        acc_valid |-> acc_kind != frame_pkg::KIND_RESERVED)
        else $error("access carries reserved kind");
    common_sock_a: assert property (
        acc_valid && acc_kind == frame_pkg::KIND_COMMON |-> acc_socket == 3'h0)
        else $error("common access with socket number");
    // pulses and held fields
    valid_pulse_a: assert property (acc_valid |=> !acc_valid)
        else $error("access pulse longer than one cycle");
    field_hold_a: assert property (
        $changed(acc_addr) |-> acc_valid || acc_reserved)
        else $error("address moved without a request");
    wdata_hold_a: assert property (
        $changed(acc_wdata) |-> acc_valid || acc_reserved)
        else $error("write data moved without a request");
    // output driver only for reads, released outside frames
    read_drive_a: assert property (!miso_oe_n |-> !acc_write)
        else $error("output driven during a write");
    cs_release_a: assert property (chip_select_n [*3] |-> miso_oe_n)
        else $error("output driven with select high");

    cover property (acc_valid && acc_write);
    cover property (acc_valid && !acc_write);
    cover property (acc_reserved);
    cover property (!miso_oe_n);
    cover property (rd_valid);
endmodule

bind frame_decode frame_decode_sva chk_u (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .chip_select_n(chip_select_n),
    .miso_oe_n(miso_oe_n), .acc_valid(acc_valid), .acc_write(acc_write),
    .acc_kind(acc_kind), .acc_socket(acc_socket), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_reserved(acc_reserved),
    .rd_valid(rd_valid));

// ===== tb/host_model.sv
// host side of the serial link: select, clock and data out, data in
// assumes the bench calls its tasks one at a time; clock idles between
module host_model (
    // serial link outputs
    output logic spi_clk,
    output logic chip_select_n,
    output logic mosi,
    // serial link inputs
    input wire logic miso_out,
    input wire logic miso_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic cpol;

    // idle link at start
    initial begin
        spi_clk = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
        cpol = 1'b0;
    end

    // clock idle level, changed only while deselected
    task automatic set_mode(input logic p);
        spi_clk = p;
        cpol = p;
    endtask

    // frame edges; released data line shows the inverse level
    task automatic select(input logic lvl);
        if (lvl && !cpol) spi_clk = 1'b0;
        #20;
        chip_select_n = lvl;
        if (lvl) mosi = ~mosi;
        #20;
    endtask

    // one byte msb first, drive on falling edge, sample on rising
    task automatic put_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            spi_clk = 1'b0;
            mosi = tx[i];
            #7.5;
            spi_clk = 1'b1;
            rx = {rx[6:0], miso_oe_n ? 1'bx : miso_out};
            #7.5;
        end
    endtask
endmodule

// ===== tb/spi_frame_control_decode_tb.sv
// self-checking bench for the serial frame control decoder
// assumes host_model on the link and the bench answering reads
module spi_frame_control_decode_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk, sys_rst, spi_clk, chip_select_n, mosi;
    logic miso_out, miso_oe_n, acc_valid, acc_write, acc_reserved;
    logic rd_valid;
    frame_pkg::kind_type acc_kind;
    logic [2:0] acc_socket;
    logic [15:0] acc_addr;
    logic [7:0] acc_wdata, rd_data, rx;
    logic [30:0] seen_q[$];
    int failures = 0, n_compared = 0, n_res = 0, cyc = 0;

    frame_decode dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .spi_clk(spi_clk), .chip_select_n(chip_select_n), .mosi(mosi),
        .miso_out(miso_out), .miso_oe_n(miso_oe_n), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_kind(acc_kind), .acc_socket(acc_socket),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata),
        .acc_reserved(acc_reserved), .rd_valid(rd_valid), .rd_data(rd_data));
    host_model host_u (.spi_clk(spi_clk), .chip_select_n(chip_select_n),
        .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n));

    // system clock
    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;

    // read answer content of the system side
    function automatic logic [7:0] exp_rd(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    // target kind of a non-reserved block code
    function automatic logic [2:0] exp_kind(input logic [4:0] b);
        return (b == 5'h00) ? 3'h0 : {1'b0, b[1:0]};
    endfunction

    // random block code, multiples of four folded onto common
    function automatic logic [4:0] rand_blk();
        logic [4:0] b;
        b = 5'($urandom);
        if (b[1:0] == 2'b00) b = 5'h00;
        return b;
    endfunction

    task check(input string what, input logic [31:0] seen,
               input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // record accesses, answer reads next cycle, watch for a hang
    always @(posedge ref_clk) begin
        #1;
        if (acc_valid === 1'b1) seen_q.push_back({acc_write, acc_kind,
            acc_socket, acc_addr, acc_write ? acc_wdata : 8'h00});
        if (acc_reserved === 1'b1) n_res++;
        rd_valid = !sys_rst && acc_valid === 1'b1 && !acc_write;
        rd_data = exp_rd(acc_addr);
        cyc++;
        if (cyc == 40000) begin
            failures++;
            wrap_up();
        end
    end

    // one frame, then compare every access it produced
    task automatic frame(input logic [15:0] a, input logic [4:0] blk,
                         input logic wr, input logic [1:0] md, input int n);
        logic [7:0] d[$];
        logic [30:0] s;
        int k, exp_n, r0;
        logic rsv;
        rsv = blk[1:0] == 2'b00 && blk != 5'h00;
        r0 = n_res;
        if (md != 2'h0) n = (md == 2'h3) ? 4 : int'(md);
        if (md == 2'h0) host_u.select(1'b0);
        host_u.put_byte(a[15:8], rx);
        host_u.put_byte(a[7:0], rx);
        host_u.put_byte({blk, wr, md}, rx);
        for (k = 0; k < n; k++) begin
            d.push_back(8'($urandom));
            if (!wr) #400;
            host_u.put_byte(d[k], rx);
            if (!wr) check("read byte", rx, exp_rd(16'(a + k)));
        end
        if (md == 2'h0) host_u.select(1'b1);
        #300;
        exp_n = rsv ? 0 : (wr || md != 2'h0) ? n : n + 1;
        k = 0;
        while (seen_q.size() > 0) begin
            s = seen_q.pop_front();
            check("access", s, {wr, exp_kind(blk), blk[4:2], 16'(a + k),
                wr ? d[k] : 8'h00});
            k++;
        end
        check("access count", k, exp_n);
        check("refusals", n_res - r0, rsv);
    endtask

    // main sequence
    initial begin
        sys_rst = 1'b1;
        void'($urandom(32'h346e));
        repeat (2) @(posedge ref_clk);
        #1 sys_rst = 1'b0;
        #100;
        // aborted frame, then corner cases
        host_u.select(1'b0);
        host_u.put_byte(8'h12, rx);
        host_u.select(1'b1);
        frame(16'h0018, 5'h00, 1'b1, 2'h0, 1);
        frame(16'h0003, 5'h1d, 1'b0, 2'h0, 1);
        frame(16'hfffe, 5'h0f, 1'b0, 2'h0, 3);
        frame(16'h0040, 5'h1c, 1'b1, 2'h0, 1);
        // random variable frames in both clock idle levels
        repeat (12) begin
            host_u.set_mode(1'($urandom_range(0, 1)));
            frame(16'($urandom), rand_blk(), 1'($urandom_range(0, 1)), 2'h0,
                  $urandom_range(1, 9));
        end
        // fixed frames back to back with select held low
        host_u.select(1'b0);
        for (int i = 0; i < 8; i++)
            frame(16'($urandom), rand_blk(), i[0], 2'(1 + i % 3), 0);
        host_u.select(1'b1);
        wrap_up();
    end
endmodule
